// ---- hw/pg_timer_pkg.sv ----
// Constants, types and timing figures shared by the power gating interval timer.
package pg_timer_pkg;

  // Clock and millisecond time base.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // Times in milliseconds, counted in millisecond ticks.
  localparam int CNT_W = 23;
  localparam logic [CNT_W-1:0] MIN_INTERVAL_MS = 23'h000064;
  localparam logic [CNT_W-1:0] MAX_INTERVAL_MS = 23'h6ddd00;
  localparam logic [CNT_W-1:0] GUARD_MS        = 23'h000032;
  localparam logic [CNT_W-1:0] MEASURE_MS      = 23'h000064;
  localparam logic [CNT_W-1:0] ZERO_CNT        = 23'h000000;
  localparam logic [CNT_W-1:0] ONE_CNT         = 23'h000001;

  // Manual request debounce window.
  localparam int DEB_W = 5;
  localparam logic [DEB_W-1:0] DEB_WINDOW_MS   = 5'h1e;
  localparam logic [DEB_W-1:0] DEB_MIN_HIGH_MS = 5'h14;

  typedef enum logic [2:0] {
    ST_MEASURE,
    ST_WAIT_RELEASE,
    ST_ON,
    ST_GUARD,
    ST_REST,
    ST_MANUAL_HOLD
  } tmr_state_e;

  // Debounce state for the manual request pin.
  typedef struct packed {
    logic [DEB_W-1:0] win;
    logic [DEB_W-1:0] high_cnt;
    logic             level;
    logic             level_prev;
  } deb_s;

  // Interval sequencer state.
  typedef struct packed {
    tmr_state_e       state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] interval_ms;
    logic             acked;
    logic             ack_prev;
  } seq_s;

endpackage

// ---- hw/power_gating_interval_timer.sv ----
// Power gating interval timer: measurement phase, periodic and one-shot gate control.
`timescale 1ns/1ps
module power_gating_interval_timer #(
  parameter int MS_CYCLES = pg_timer_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Pins facing the board and the microcontroller.
  input  wire logic                           interval_res_or_manual_on,
  input  wire logic                           mode_periodic,
  input  wire logic                           done_ack,
  // Result of the analog resistor conversion, in milliseconds.
  input  wire logic [pg_timer_pkg::CNT_W-1:0] measured_interval_ms,
  // Outputs.
  output logic                                gate_out_n,
  output logic                                measuring
);
  import pg_timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider.

  logic [31:0] pre;
  logic [31:0] next_pre;
  logic        ms_tick;
  logic        next_ms_tick;

  always_comb
  begin
    next_ms_tick = 1'b0;
    next_pre     = pre + 32'h00000001;
    if (pre == 32'(MS_CYCLES - 1))
    begin
      next_pre     = 32'h00000000;
      next_ms_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre     <= 32'h00000000;
      ms_tick <= 1'b0;
    end
    else
    begin
      pre     <= next_pre;
      ms_tick <= next_ms_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manual request debounce, evaluated once per 30ms window on both edges.

  deb_s deb;
  deb_s next_deb;
  logic manual_rise;
  logic manual_fall;

  always_comb
  begin
    next_deb            = deb;
    next_deb.level_prev = deb.level;
    if (ms_tick)
    begin
      next_deb.win      = deb.win + 5'h01;
      next_deb.high_cnt = deb.high_cnt + {4'h0, interval_res_or_manual_on};
      if (deb.win == DEB_WINDOW_MS - 5'h01)
      begin
        // A short glitch cannot reach 20 high samples, and a short dropout
        // cannot pull the count below it, so both edges are filtered.
        next_deb.level    = (next_deb.high_cnt >= DEB_MIN_HIGH_MS);
        next_deb.win      = 5'h00;
        next_deb.high_cnt = 5'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deb <= '0;
    end
    else
    begin
      deb <= next_deb;
    end
  end

  assign manual_rise = deb.level & ~deb.level_prev;
  assign manual_fall = ~deb.level & deb.level_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Interval sequencer.

  function automatic logic [CNT_W-1:0] clamp_interval(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    r = v;
    if (v < MIN_INTERVAL_MS)
    begin
      r = MIN_INTERVAL_MS;
    end
    else if (v > MAX_INTERVAL_MS)
    begin
      r = MAX_INTERVAL_MS;
    end
    return r;
  endfunction

  function automatic logic is_gate_on(input tmr_state_e s);
    return (s == ST_ON) || (s == ST_MANUAL_HOLD);
  endfunction

  seq_s seq;
  seq_s next_seq;
  logic ack_edge;
  logic next_gate_out_n;
  logic next_measuring;

  assign ack_edge = done_ack & ~seq.ack_prev;

  always_comb
  begin
    next_seq          = seq;
    next_seq.ack_prev = done_ack;
    case (seq.state)
      ST_MEASURE:
      begin
        if (interval_res_or_manual_on)
        begin
          next_seq.state = ST_WAIT_RELEASE;
          next_seq.cnt   = ZERO_CNT;
        end
        else if (ms_tick)
        begin
          next_seq.cnt = seq.cnt + ONE_CNT;
          if (seq.cnt == MEASURE_MS - ONE_CNT)
          begin
            next_seq.interval_ms = clamp_interval(measured_interval_ms);
            next_seq.cnt         = ZERO_CNT;
            next_seq.acked       = 1'b0;
            // Both modes open with one pulse; the mode only decides what follows.
            next_seq.state       = ST_ON;
          end
        end
      end
      ST_WAIT_RELEASE:
      begin
        if (!interval_res_or_manual_on)
        begin
          next_seq.state = ST_MEASURE;
          next_seq.cnt   = ZERO_CNT;
        end
      end
      ST_ON:
      begin
        // While the switch is on, a manual request only blocks the acknowledge; its rise is dropped.
        if (ack_edge && !seq.acked && !interval_res_or_manual_on)
        begin
          next_seq.acked = 1'b1;
          next_seq.state = ST_GUARD;
        end
        if (ms_tick)
        begin
          next_seq.cnt = seq.cnt + ONE_CNT;
          if (seq.cnt + ONE_CNT >= seq.interval_ms - GUARD_MS)
          begin
            next_seq.state = ST_GUARD;
          end
        end
      end
      ST_GUARD:
      begin
        if (ack_edge && !interval_res_or_manual_on)
        begin
          next_seq.acked = 1'b1;
        end
        if (manual_rise)
        begin
          next_seq.state = ST_MANUAL_HOLD;
          next_seq.cnt   = ZERO_CNT;
        end
        else if (ms_tick)
        begin
          next_seq.cnt = seq.cnt + ONE_CNT;
          if (seq.cnt + ONE_CNT >= seq.interval_ms)
          begin
            next_seq.cnt   = ZERO_CNT;
            next_seq.acked = 1'b0;
            next_seq.state = mode_periodic ? ST_ON : ST_REST;
          end
        end
      end
      ST_REST:
      begin
        next_seq.cnt = ZERO_CNT;
        if (manual_rise)
        begin
          next_seq.state = ST_MANUAL_HOLD;
        end
      end
      ST_MANUAL_HOLD:
      begin
        // Counting only restarts on the debounced fall, so the low time can
        // drift by part of a debounce window against the raw pin.
        next_seq.cnt   = ZERO_CNT;
        next_seq.acked = 1'b0;
        if (manual_fall)
        begin
          next_seq.state = ST_ON;
        end
      end
      default:
      begin
        next_seq = '0;
      end
    endcase
    next_gate_out_n = ~is_gate_on(next_seq.state);
    next_measuring  = (next_seq.state == ST_MEASURE) || (next_seq.state == ST_WAIT_RELEASE);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq        <= '0;
      gate_out_n <= 1'b1;
      measuring  <= 1'b1;
    end
    else
    begin
      seq        <= next_seq;
      gate_out_n <= next_gate_out_n;
      measuring  <= next_measuring;
    end
  end

endmodule

// ---- sim/pg_timer_checker.sv ----
// Port assertions for the power gating interval timer.
`timescale 1ns/1ps
module pg_timer_checker #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset.
  input wire logic                           clk,
  input wire logic                           rst_n,
  // Timer pins.
  input wire logic                           interval_res_or_manual_on,
  input wire logic                           mode_periodic,
  input wire logic                           done_ack,
  input wire logic [pg_timer_pkg::CNT_W-1:0] measured_interval_ms,
  input wire logic                           gate_out_n,
  input wire logic                           measuring
);
  import pg_timer_pkg::*;
  logic        g_q, seen, ackd, man, fall, rise;
  logic [31:0] since, low_cnt, hcnt, per;
  assign per  = 32'(measured_interval_ms) * MS_CYCLES;
  assign fall = g_q & ~gate_out_n;
  assign rise = ~g_q & gate_out_n;
  ////////////////////////////////////////
  // Spans run to thousands of cycles, so run lengths live in counters.
  always_ff @(posedge clk)
  begin
    g_q     <= gate_out_n | ~rst_n;
    seen    <= rst_n & (seen | fall);
    ackd    <= ~fall & (ackd | (done_ack & ~gate_out_n));
    man     <= rst_n & ~fall & ~rise & (man | (interval_res_or_manual_on & ~measuring));
    since   <= fall ? 32'h1 : since + 32'h1;
    low_cnt <= gate_out_n ? 32'h0 : low_cnt + 32'h1;
    hcnt    <= interval_res_or_manual_on ? hcnt + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_meas_gate_off: assert property (measuring |-> gate_out_n)
    else $error("gate on during measurement");
  a_abort_hold: assert property (interval_res_or_manual_on && measuring |=> measuring)
    else $error("measurement not held by manual pin");
  a_first_pulse: assert property ($fell(measuring) |-> ##[0:2] !gate_out_n)
    else $error("no pulse after measurement");
  a_ack_stops: assert property ($rose(done_ack) && !gate_out_n &&
    !interval_res_or_manual_on |-> ##2 gate_out_n)
    else $error("acknowledge did not end pulse");
  a_period_len: assert property (fall && seen && mode_periodic |-> since == per)
    else $error("periodic spacing wrong");
  a_on_len: assert property (rise && mode_periodic && !ackd |->
    low_cnt == per - 32'(GUARD_MS) * MS_CYCLES)
    else $error("on time wrong");
  a_one_shot_quiet: assert property (fall && !mode_periodic |-> $past(measuring) || man)
    else $error("one-shot pulse without request");
  a_manual_on: assert property (hcnt >= 61 * MS_CYCLES && !measuring |-> !gate_out_n)
    else $error("manual request not honoured");
endmodule
bind power_gating_interval_timer pg_timer_checker #(.MS_CYCLES(MS_CYCLES)) u_pg_timer_checker (
  .clk(clk), .rst_n(rst_n), .interval_res_or_manual_on(interval_res_or_manual_on),
  .mode_periodic(mode_periodic), .done_ack(done_ack), .gate_out_n(gate_out_n),
  .measured_interval_ms(measured_interval_ms), .measuring(measuring));

// ---- sim/mcu_model.sv ----
// Microcontroller model: answers each power-on with one acknowledge pulse.
`timescale 1ns/1ps
module mcu_model (
  // Clock and gate from the timer.
  input  wire logic clk,
  input  wire logic gate_out_n,
  // Answer at all, and answer late.
  input  wire logic en,
  input  wire logic slow,
  // Acknowledge back to the timer.
  output logic      done_ack
);
  int cnt;
  int hold;
  always @(posedge clk)
  begin
    cnt = (en && !gate_out_n) ? cnt + 1 : 0;
    if (cnt == (slow ? 300 : 50))
      hold = 8;
    else if (hold > 0)
      hold = hold - 1;
    done_ack <= (hold > 0);
  end
endmodule

// ---- sim/power_gating_interval_timer_bench.sv ----
// Self-checking bench for the power gating interval timer.
`timescale 1ns/1ps
module power_gating_interval_timer_bench;
  import pg_timer_pkg::*;
  // A millisecond shrinks to 10 cycles so a 100 ms interval takes 1000 cycles.
  localparam int MS = 10;
  localparam int PER = 100 * MS;
  localparam int ON = PER - 50 * MS;
  logic             clk, rst_n, pin, mode, en, slow, done_ack, gate_out_n, measuring;
  logic [CNT_W-1:0] iv;
  int               fails, n_tests, c;
  power_gating_interval_timer #(.MS_CYCLES(MS)) u_power_gating_interval_timer (
    .clk(clk), .rst_n(rst_n), .interval_res_or_manual_on(pin), .mode_periodic(mode),
    .done_ack(done_ack), .measured_interval_ms(iv), .gate_out_n(gate_out_n),
    .measuring(measuring));
  mcu_model u_mcu_model (.clk(clk), .gate_out_n(gate_out_n), .en(en), .slow(slow),
    .done_ack(done_ack));
  ////////////////////////////////////////
  task automatic chk(input string what, input int lo, input int hi, input logic [31:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'h1)
    begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wait_gate(input logic v, input int max);
    c = 0;
    while (gate_out_n !== v && c < max)
    begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic do_reset(input logic m, input logic p);
    rst_n = 1'h0;
    mode = m;
    pin = p;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
  endtask
  task automatic t_startup();
    do_reset(1'h1, 1'h0);
    repeat (PER - 100) @(negedge clk);
    chk("gate while measuring", 1, 1, gate_out_n);
    wait_gate(1'h0, 200);
    chk("measure time", PER - 10, PER + 10, PER - 100 + c);
    chk("measuring", 0, 0, measuring);
    $display("t_startup done");
  endtask
  task automatic t_periodic(input logic e, input logic s);
    int lo;
    int hi;
    int on_t;
    en = e;
    slow = s;
    lo = e ? (s ? 300 : 50) : ON;
    hi = e ? lo + 5 : ON;
    repeat (2)
    begin
      wait_gate(1'h0, 2 * PER);
      wait_gate(1'h1, PER);
      on_t = c;
      chk("on time", lo, hi, on_t);
      wait_gate(1'h0, PER);
      chk("off time", PER - hi, PER - lo, c);
      chk("period", PER, PER, on_t + c);
    end
    $display("t_periodic done");
  endtask
  task automatic t_one_shot();
    en = 1'h0;
    iv = MIN_INTERVAL_MS - GUARD_MS;
    do_reset(1'h0, 1'h1);
    repeat (3 * PER / 2) @(negedge clk);
    chk("abort hold", 1, 1, measuring);
    pin = 1'h0;
    wait_gate(1'h0, 2 * PER);
    chk("restart time", PER - 10, PER + 10, c);
    repeat (5) @(negedge clk);
    pin = 1'h1;
    repeat (250) @(negedge clk);
    pin = 1'h0;
    wait_gate(1'h1, PER);
    chk("single pulse", ON, ON, 255 + c);
    wait_gate(1'h0, 3 * PER);
    chk("stays off", 3 * PER, 3 * PER, c);
    $display("t_one_shot done");
  endtask
  task automatic t_manual();
    iv = MIN_INTERVAL_MS + MIN_INTERVAL_MS;
    pin = 1'h1;
    repeat (50) @(negedge clk);
    pin = 1'h0;
    wait_gate(1'h0, PER);
    chk("glitch ignored", PER, PER, c);
    en = 1'h1;
    pin = 1'h1;
    wait_gate(1'h0, PER);
    chk("manual on", 0, 61 * MS, c);
    repeat (PER) @(negedge clk);
    pin = 1'h0;
    repeat (50) @(negedge clk);
    pin = 1'h1;
    repeat (PER) @(negedge clk);
    chk("held on", 0, 0, gate_out_n);
    en = 1'h0;
    pin = 1'h0;
    wait_gate(1'h1, 2 * PER);
    chk("release pulse", ON, ON + 62 * MS, c);
    wait_gate(1'h0, 2 * PER);
    chk("no repeat", 2 * PER, 2 * PER, c);
    $display("t_manual done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #1000000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    rst_n = 1'h0;
    pin = 1'h0;
    mode = 1'h1;
    en = 1'h0;
    slow = 1'h0;
    iv = MIN_INTERVAL_MS;
    fails = 0;
    n_tests = 0;
    t_startup();
    t_periodic(1'h0, 1'h0);
    t_periodic(1'h1, 1'h0);
    t_periodic(1'h1, 1'h1);
    t_one_shot();
    t_manual();
    report_and_stop();
  end
endmodule
